// ---- hw/line_fault_pkg.sv ----
// constants, types and register map of the line fault monitor
// assumes an APB master on the core clock and 32-bit data
// ***************************************************************
// ***************************************************************
package line_fault_pkg;

  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int NUM_DET = 4;
  localparam int COND_W  = 3;

  // ***************************************************************
  // register offsets (byte addresses)
  // ***************************************************************
  localparam logic [ADDR_W-1:0] OFS_POWER_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS_HI  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS_LO  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_CONFIG     = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 12'h01C;

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int FAULT_BIT     = 3;
  localparam int STICKY_BIT    = 0;
  localparam int HI_FIELD_LSB  = 4;
  localparam int LO_FIELD_LSB  = 0;
  localparam logic [NUM_DET-1:0] POWER_RESET = 4'h0;
  localparam logic [NUM_DET-1:0] MASK_RESET  = 4'h0;

  // ***************************************************************
  // condition codes
  // ***************************************************************
  localparam logic [COND_W-1:0] COND_SHORT_BAT = 3'h0;
  localparam logic [COND_W-1:0] COND_SHORT_GND = 3'h1;
  localparam logic [COND_W-1:0] COND_NORMAL    = 3'h2;
  localparam logic [COND_W-1:0] COND_OPEN      = 3'h3;
  localparam int                COND_L2L_BIT   = 2;

  typedef logic [COND_W-1:0] cond_t;
  typedef cond_t [NUM_DET-1:0] cond_vec_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

endpackage

// ---- hw/cond_sync.sv ----
// two-flop synchroniser for the analog detector condition codes
// assumes the codes are quasi-static levels from the analog side
module cond_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // data
  input  wire logic [WIDTH-1:0] rawIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1Reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1Reg <= '0;
      syncOut   <= '0;
    end else begin
      stage1Reg <= rawIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule

// ---- hw/line_fault_monitor.sv ----
// line fault monitor: detector power, condition status, fault interrupt
// assumes APB master on clk_sys and asynchronous analog condition inputs
module line_fault_monitor (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  // apb slave
  input  wire line_fault_pkg::apb_req_s     apbReq,
  output logic [line_fault_pkg::DATA_W-1:0] prdata,
  output logic                              pready,
  output logic                              pslverr,
  // analog detectors
  input  wire line_fault_pkg::cond_vec_t    detectorCondRaw,
  output logic [line_fault_pkg::NUM_DET-1:0] detectorPowerUp,
  // alerts
  output logic                              error_alert_n,
  output logic                              irq
);
  import line_fault_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  logic [NUM_DET-1:0] powerReg;
  logic               irqOenReg;
  logic               stickyReg;
  logic               flagReg;
  logic               flagNext;
  logic [NUM_DET-1:0] evtReg;
  logic [NUM_DET-1:0] evtNext;
  logic [NUM_DET-1:0] maskReg;
  logic [NUM_DET-1:0] faultPrevReg;
  logic [DATA_W-1:0]  rdataNext;
  cond_vec_t          condSync;
  cond_vec_t          condCode;
  logic [NUM_DET-1:0] faultNow;
  logic               anyFault;

  function automatic logic addrIs(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] ofs);
    addrIs = (a == ofs);
  endfunction

  // ***************************************************************
  // detector inputs
  // ***************************************************************
  cond_sync #(
    .WIDTH (NUM_DET*COND_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .rawIn   (detectorCondRaw),
    .syncOut (condSync)
  );

  // unpowered detectors read healthy whatever the line does
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DET; gi++) begin : g_det
      assign condCode[gi] = powerReg[gi] ? condSync[gi]
                                         : COND_NORMAL;
      // 000, 001, 011 and 1xx are all faults
      assign faultNow[gi] = (condCode[gi] != COND_NORMAL);
    end
  endgenerate

  assign anyFault = |faultNow;

  // ***************************************************************
  // bus decode
  // ***************************************************************
  wire setup     = apbReq.psel & apbReq.penable & ~pready;
  wire complete  = apbReq.psel & apbReq.penable & pready;
  wire wrDone    = complete & apbReq.pwrite;
  wire rdDone    = complete & ~apbReq.pwrite;
  wire [ADDR_W-1:0] addr = apbReq.paddr;
  wire hitPower  = addrIs(addr, OFS_POWER_CTRL);
  wire hitStHi   = addrIs(addr, OFS_STATUS_HI);
  wire hitStLo   = addrIs(addr, OFS_STATUS_LO);
  wire hitIrqEn  = addrIs(addr, OFS_IRQ_ENABLE);
  wire hitIrqSt  = addrIs(addr, OFS_IRQ_STATUS);
  wire hitCfg    = addrIs(addr, OFS_CONFIG);
  wire hitEvtSt  = addrIs(addr, OFS_EVT_STATUS);
  wire hitMask   = addrIs(addr, OFS_EVT_MASK);
  wire hitAny    = hitPower | hitStHi | hitStLo | hitIrqEn | hitIrqSt
                 | hitCfg | hitEvtSt | hitMask;
  wire readClr   = rdDone & hitIrqSt;
  wire [NUM_DET-1:0] w1c = (wrDone & hitEvtSt)
                         ? apbReq.pwdata[NUM_DET-1:0] : '0;

  // status pair layout, bit 3 and bits above 6 read zero
  wire [DATA_W-1:0] stHiWord = DATA_W'({condCode[3], 1'b0,
                                        condCode[2]});
  wire [DATA_W-1:0] stLoWord = DATA_W'({condCode[1], 1'b0,
                                        condCode[0]});

  always_comb begin
    rdataNext = '0;
    if (hitPower) rdataNext[NUM_DET-1:0] = powerReg;
    if (hitStHi)  rdataNext = stHiWord;
    if (hitStLo)  rdataNext = stLoWord;
    if (hitIrqEn) rdataNext[FAULT_BIT] = irqOenReg;
    if (hitIrqSt) rdataNext[FAULT_BIT] = flagReg;
    if (hitCfg)   rdataNext[STICKY_BIT] = stickyReg;
    if (hitEvtSt) rdataNext[NUM_DET-1:0] = evtReg;
    if (hitMask)  rdataNext[NUM_DET-1:0] = maskReg;
  end

  // one wait state: data and error are captured with pready
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hitAny;
      if (setup) begin
        prdata <= apbReq.pwrite ? '0 : rdataNext;
      end
    end
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      powerReg  <= POWER_RESET;
      irqOenReg <= 1'b0;
      stickyReg <= 1'b0;
      maskReg   <= MASK_RESET;
    end else if (wrDone) begin
      if (hitPower) powerReg  <= apbReq.pwdata[NUM_DET-1:0];
      if (hitIrqEn) irqOenReg <= apbReq.pwdata[FAULT_BIT];
      if (hitCfg)   stickyReg <= apbReq.pwdata[STICKY_BIT];
      if (hitMask)  maskReg   <= apbReq.pwdata[NUM_DET-1:0];
    end
  end

  // ***************************************************************
  // fault flag and error pin
  // ***************************************************************
  // latched flag: a fault still present at the read keeps it set
  assign flagNext = stickyReg
                  ? (anyFault | (flagReg & ~readClr))
                  : anyFault;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flagReg       <= 1'b0;
      error_alert_n <= 1'b1;
    end else begin
      flagReg       <= flagNext;
      error_alert_n <= ~(flagReg & irqOenReg);
    end
  end

  // ***************************************************************
  // per-detector onset events and interrupt output
  // ***************************************************************
  // onset detect only; a steady fault raises one event
  assign evtNext = (evtReg & ~w1c) | (faultNow & ~faultPrevReg);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      faultPrevReg <= '0;
      evtReg       <= '0;
      irq          <= 1'b0;
    end else begin
      faultPrevReg <= faultNow;
      evtReg       <= evtNext;
      irq          <= |(evtReg & maskReg);
    end
  end

  assign detectorPowerUp = powerReg;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_power_write;
    wrDone && hitPower |=> detectorPowerUp == $past(apbReq.pwdata[3:0]);
  endproperty
  a_power_write: assert property (p_power_write)
    else $error("power bits do not follow the write");

  property p_status_lo;
    setup && hitStLo && !apbReq.pwrite |=>
      prdata[6:4] == $past(condCode[1]) && prdata[2:0] == $past(condCode[0])
      && prdata[3] == 1'b0;
  endproperty
  a_status_lo: assert property (p_status_lo)
    else $error("low status pair layout wrong");

  property p_unpowered_normal;
    !powerReg[0] |-> condCode[0] == 3'h2;
  endproperty
  a_unpowered_normal: assert property (p_unpowered_normal)
    else $error("unpowered detector not healthy");

  property p_fault_sets_flag;
    powerReg[1] && condSync[1] inside {3'h0, 3'h1, 3'h3, 3'h4}
      |=> flagReg;
  endproperty
  a_fault_sets_flag: assert property (p_fault_sets_flag)
    else $error("fault did not set the flag");

  property p_live_flag;
    !stickyReg |=> flagReg == $past(anyFault);
  endproperty
  a_live_flag: assert property (p_live_flag)
    else $error("live flag does not track the fault");

  property p_pin_routed;
    flagReg && irqOenReg |=> !error_alert_n;
  endproperty
  a_pin_routed: assert property (p_pin_routed)
    else $error("routed fault did not pull the pin low");

  property p_pin_release;
    !stickyReg ##1 (!anyFault && !stickyReg)[*2] |=> error_alert_n;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("pin not released after fault cleared");

  property p_sticky_hold;
    stickyReg && flagReg && !readClr |=> flagReg;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("latched flag dropped without a read");

  property p_read_clear;
    stickyReg && readClr && !anyFault |=> !flagReg;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read did not clear the latched flag");

  property p_sync_delay;
    // the flops hold zero until two edges after reset lets go
    $past(nrst, 2) |-> condSync == $past(detectorCondRaw, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("condition inputs not two flops late");

  property p_short_bat;
    powerReg[0] && condSync[0] == COND_SHORT_BAT |=> flagReg;
  endproperty
  a_short_bat: assert property (p_short_bat)
    else $error("short to battery did not raise the flag");

  property p_short_gnd;
    powerReg[1] && condSync[1] == COND_SHORT_GND |=> flagReg;
  endproperty
  a_short_gnd: assert property (p_short_gnd)
    else $error("short to ground did not raise the flag");

  property p_open_line;
    powerReg[3] && condSync[3] == COND_OPEN |=> flagReg;
  endproperty
  a_open_line: assert property (p_open_line)
    else $error("open line did not raise the flag");

  property p_line_short;
    powerReg[2] && condSync[2][COND_L2L_BIT] |=> flagReg;
  endproperty
  a_line_short: assert property (p_line_short)
    else $error("line-to-line short did not raise the flag");

  property p_unpowered_hi;
    !powerReg[3] |-> condCode[3] == COND_NORMAL;
  endproperty
  a_unpowered_hi: assert property (p_unpowered_hi)
    else $error("unpowered detector 3 not healthy");

  property p_status_hi;
    setup && hitStHi && !apbReq.pwrite |=>
      prdata[6:4] == $past(condCode[3]) && prdata[2:0] == $past(condCode[2])
      && prdata[3] == 1'b0;
  endproperty
  a_status_hi: assert property (p_status_hi)
    else $error("high status pair layout wrong");

  property p_pin_unrouted;
    !irqOenReg |=> error_alert_n;
  endproperty
  a_pin_unrouted: assert property (p_pin_unrouted)
    else $error("unrouted fault pulled the pin low");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready stood longer than one cycle");

  property p_unmapped;
    setup && !hitAny |=> pready && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without error response");

  property p_evt_onset;
    faultNow[0] && !faultPrevReg[0] |=> evtReg[0];
  endproperty
  a_evt_onset: assert property (p_evt_onset)
    else $error("fault onset did not set the event bit");

  property p_irq_masked;
    !(|(evtReg & maskReg)) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised with no unmasked event");

endmodule

// ---- bench/line_detector_model.sv ----
// behavioural analog line-fault detectors facing the monitor
// assumes the bench commands the codes; local end only, no coax power
module line_detector_model (
  // clock
  input  wire logic                         clk_sys,
  // power from the monitor, wanted codes from the bench
  input  wire logic [line_fault_pkg::NUM_DET-1:0] powerUp,
  input  wire line_fault_pkg::cond_vec_t    cmdCond,
  // detector outputs
  output line_fault_pkg::cond_vec_t         condRaw
);
  timeunit 1ns;
  timeprecision 1ps;
  import line_fault_pkg::*;
  // local end of a link without coax power
  initial condRaw = '0;
  // unpowered outputs float: toggle so a stale code never holds steady
  always @(posedge clk_sys) begin
    for (int i = 0; i < NUM_DET; i++) begin
      condRaw[i] <= powerUp[i] ? cmdCond[i] : ~condRaw[i];
    end
  end
endmodule

// ---- bench/test_line_fault_monitor.sv ----
// self-checking bench for the line fault monitor
// assumes the detector model is compiled before this file
module test_line_fault_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import line_fault_pkg::*;
  // ***************************************************************
  // signals and expected state
  // ***************************************************************
  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  apb_req_s    req     = '0;
  cond_vec_t   cmd     = '0;
  cond_vec_t   raw;
  logic [31:0] prdata, rd;
  logic [3:0]  pwr;
  logic        pready, pslverr, error_alert_n, irq, se;
  int          err_count = 0;
  int          n_compared = 0;
  int          pw, sticky, latched, cd[4];
  always #10 clk_sys = ~clk_sys;
  line_fault_monitor dut (.clk_sys(clk_sys), .nrst(nrst),
    .apbReq(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .detectorCondRaw(raw), .detectorPowerUp(pwr),
    .error_alert_n(error_alert_n), .irq(irq));
  line_detector_model det (.clk_sys(clk_sys), .powerUp(pwr),
    .cmdCond(cmd), .condRaw(raw));
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one edge first, so the previous release is never overwritten
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      complete_run();
    end
    rd = prdata;
    se = pslverr;
    req <= '0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  function automatic int shown(int i);
    return pw[i] ? cd[i] : 2;
  endfunction
  function automatic int fault();
    int f = 0;
    for (int i = 0; i < 4; i++) f |= (shown(i) != 2);
    return f;
  endfunction
  // latency through the sync stages and flag is fixed; 6 edges covers it
  task automatic settle();
    for (int i = 0; i < 4; i++) cmd[i] <= 3'(cd[i]);
    repeat (6) @(posedge clk_sys);
    if (sticky != 0 && fault() != 0) latched = 1;
  endtask
  task automatic check_all();
    rchk(OFS_STATUS_HI, 32'(shown(3) * 16 + shown(2)));
    rchk(OFS_STATUS_LO, 32'(shown(1) * 16 + shown(0)));
    rchk(OFS_IRQ_STATUS, 32'((latched | fault()) << FAULT_BIT));
    latched = sticky & fault();
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    void'($urandom(54333));
    pw = 0;
    sticky = 0;
    latched = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rchk(OFS_POWER_CTRL, 32'(POWER_RESET));
    foreach (cd[i]) cd[i] = $urandom_range(7);
    settle();
    check_all();
    for (int c = 0; c < 8; c++) begin
      pw = $urandom_range(15) | (1 << (c % 4));
      apb(1'b1, OFS_POWER_CTRL, 32'(pw));
      rchk(OFS_POWER_CTRL, 32'(pw));
      chk(32'(pwr), 32'(pw));
      foreach (cd[i]) cd[i] = (i == c % 4) ? c : $urandom_range(7);
      settle();
      check_all();
    end
    apb(1'b1, OFS_STATUS_LO, 32'h0000_00FF);
    check_all();
    pw = 3;
    apb(1'b1, OFS_POWER_CTRL, 32'(pw));
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0008);
    cd = '{2, 2, 2, 2};
    cd[0] = 1;
    settle();
    chk(32'(error_alert_n), 32'h0000_0000);
    cd[0] = 2;
    settle();
    chk(32'(error_alert_n), 32'h0000_0001);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0000);
    cd[1] = 0;
    settle();
    chk(32'(error_alert_n), 32'h0000_0001);
    cd[1] = 2;
    sticky = 1;
    apb(1'b1, OFS_CONFIG, 32'h0000_0001);
    cd[0] = 3;
    settle();
    cd[0] = 2;
    settle();
    check_all();
    check_all();
    sticky = 0;
    apb(1'b1, OFS_CONFIG, 32'h0000_0000);
    apb(1'b1, OFS_EVT_STATUS, 32'h0000_000F);
    rchk(OFS_EVT_STATUS, 32'h0000_0000);
    apb(1'b1, OFS_EVT_MASK, 32'h0000_0001);
    rchk(OFS_EVT_MASK, 32'h0000_0001);
    cd[1] = 1;
    settle();
    chk(32'(irq), 32'h0000_0000);
    cd[0] = 4;
    settle();
    chk(32'(irq), 32'h0000_0001);
    rchk(OFS_EVT_STATUS, 32'h0000_0003);
    cd = '{2, 2, 2, 2};
    settle();
    apb(1'b1, OFS_EVT_STATUS, 32'h0000_0001);
    // irq is one register behind the event bits it summarises
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h0000_0000);
    rchk(OFS_EVT_STATUS, 32'h0000_0002);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(32'(se), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    complete_run();
  end
endmodule
